/* rtl/clf_regs.vh */
// Constants of the CAN local failure and wake supervision block.
// Assumes a 200 MHz pclk and a 32-bit APB register bus.
`ifndef CLF_REGS_VH
`define CLF_REGS_VH

// Clock period in nanoseconds.
`define CLF_CLK_NS 5

// Times in nanoseconds, plain defaults.
`define CLF_TXD_TO_NS 2000000
`define CLF_BUS_TO_NS 2000000
`define CLF_FLTR_NS 500
`define CLF_WAKE_NS 50000

// Derived cycle counts.
`define CLF_TXD_TO_CYC (`CLF_TXD_TO_NS / `CLF_CLK_NS)
`define CLF_BUS_TO_CYC (`CLF_BUS_TO_NS / `CLF_CLK_NS)
`define CLF_FLTR_CYC (`CLF_FLTR_NS / `CLF_CLK_NS)
`define CLF_WAKE_CYC (`CLF_WAKE_NS / `CLF_CLK_NS)

// Register byte offsets.
`define CLF_OFS_CTRL 8'h00
`define CLF_OFS_STATUS 8'h04
`define CLF_OFS_EVENT 8'h08

// Control fields.
`define CLF_CTRL_TX_ALLOW 0
`define CLF_CTRL_WAKE_EN 1
`define CLF_CTRL_RST 2'h3

// Status fields.
`define CLF_ST_LF 0
`define CLF_ST_TXD 1
`define CLF_ST_SHORT 2
`define CLF_ST_BUS 3
`define CLF_ST_OT 4
`define CLF_ST_TXEN 5
`define CLF_ST_NORMAL 6
`define CLF_ST_LISTEN 7
`define CLF_ST_WAKELVL 8

// Event fields, write one to clear.
`define CLF_EV_WAKE 0

`endif

/* rtl/clf_stable_filter.v */
// Level filter: the output takes a new input level only after it stood for TERM cycles.
// Assumes the input is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module clf_stable_filter #(
  parameter CNT_W = 16,
  parameter [CNT_W-1:0] TERM = 16'h0064,
  parameter RST_VAL = 1'b0
) (
  // Clock and reset.
  input wire clk,
  input wire rst_n,
  // Level in and settled level out.
  input wire d,
  output reg q_q,
  output reg changed_q
);

  reg [CNT_W-1:0] cnt_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= RST_VAL;
      cnt_q <= {CNT_W{1'b0}};
      changed_q <= 1'b0;
    end else begin
      changed_q <= 1'b0;
      if (d == q_q) begin
        cnt_q <= {CNT_W{1'b0}};
      end else if (cnt_q >= TERM - 1'b1) begin
        q_q <= d;
        cnt_q <= {CNT_W{1'b0}};
        changed_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule // clf_stable_filter
`default_nettype wire

/* rtl/clf_local_failure.v */
// Local failure supervision, mode input filtering and local wake detection.
// Assumes all pin inputs are synchronous to pclk; registers sit on APB.
//
// Operation
// RULE_01: In Normal or Listen-only, any of four local failures sets the flag.
// RULE_02: Error output shows the local failure flag only in Listen-only entered from Normal.
// RULE_03: Power-on flag set clears the local failure flag.
// RULE_04: With all failures resolved, entering Normal clears the flag.
// RULE_05: With all failures resolved, receive dominant while transmit recessive clears it.
// RULE_06: A falling edge on transmit data restarts the transmit-dominant timer.
// RULE_07: Transmit low beyond timeout disables the transmitter and sets the flag.
// RULE_08: After transmit timeout or short, transmitter stays off until flag cleared.
// RULE_09: Transmit data high resets the transmit-dominant timer.
// RULE_10: A transmit-to-receive short disables the transmitter and sets the flag.
// RULE_11: Bus dominant beyond bus timeout sets the flag.
// RULE_12: A bus-dominant failure leaves the transmitter enabled.
// RULE_13: Bus back to recessive clears a flag set only by bus-dominant failure.
// RULE_14: Overtemperature turns drivers off until thermal release and flag cleared.
// RULE_15: Mode input pulses shorter than the filter time are suppressed.
// RULE_16: A wake pin change stable for the wake time registers a local wake.
// RULE_17: A wake pin level not stable for the wake time registers nothing.
// RULE_18: After the wake delay the wake bias follows the settled level.
// RULE_19: Error output low means flag set, high means not set.
// RULE_20: All four times are counters of the clock with parameter terminal counts.
`timescale 1ns/1ps
`default_nettype none
`include "clf_regs.vh"
module clf_local_failure #(
  parameter TXD_TO_CYC = `CLF_TXD_TO_CYC,
  parameter BUS_TO_CYC = `CLF_BUS_TO_CYC,
  parameter FLTR_CYC = `CLF_FLTR_CYC,
  parameter WAKE_CYC = `CLF_WAKE_CYC
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Host side pins.
  input wire txd,
  input wire rxd_pin,
  output reg rxd,
  output reg err_n,
  input wire standby_select_n,
  input wire enable,
  // Bus side and analog status.
  input wire bus_dominant,
  output reg tx_enable,
  input wire pwon,
  input wire thermal_shutdown_temp,
  input wire thermal_release_temp,
  // Wake pin.
  input wire wake_pin,
  output reg wake_pullup,
  output reg local_wake
);

  ////////////////////////////////////////////////////////////////////////////////
  // Mode inputs and mode tracking.

  localparam MODE_STBY = 2'b00;
  localparam MODE_NORMAL = 2'b01;
  localparam MODE_LISTEN = 2'b10;

  wire stb_f;
  wire en_f;
  wire wake_f;
  wire wake_chg;
  reg [1:0] mode;
  reg [1:0] mode_q;
  reg lo_from_norm_q;

  clf_stable_filter #(
    .CNT_W(32),
    .TERM(FLTR_CYC),
    .RST_VAL(1'b0)
  ) u_stb_fltr (
    .clk(pclk),
    .rst_n(presetn),
    .d(standby_select_n),
    .q_q(stb_f),
    .changed_q()
  ); // [RULE_15] [RULE_20]

  clf_stable_filter #(
    .CNT_W(32),
    .TERM(FLTR_CYC),
    .RST_VAL(1'b0)
  ) u_en_fltr (
    .clk(pclk),
    .rst_n(presetn),
    .d(enable),
    .q_q(en_f),
    .changed_q()
  ); // [RULE_15] [RULE_20]

  // Standby unless the select input is high; enable then picks Normal over Listen-only.
  always @* begin
    if (stb_f && en_f) begin
      mode = MODE_NORMAL;
    end else if (stb_f) begin
      mode = MODE_LISTEN;
    end else begin
      mode = MODE_STBY;
    end
  end

  // Entering Normal is a one-cycle pulse; with all failures resolved it clears the flag.
  wire in_normal = (mode == MODE_NORMAL);
  wire in_listen = (mode == MODE_LISTEN);
  wire active = in_normal || in_listen;
  wire enter_normal = in_normal && (mode_q != MODE_NORMAL);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_STBY;
      lo_from_norm_q <= 1'b0;
    end else begin
      mode_q <= mode;
      case (mode)
        MODE_NORMAL: lo_from_norm_q <= 1'b1;
        MODE_LISTEN: lo_from_norm_q <= lo_from_norm_q;
        default: lo_from_norm_q <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Dominant timers.

  // Both counters stop at their terminal count, so a very long dominant phase cannot
  // wrap around and hide a timeout that is still pending.
  reg [31:0] txd_cnt_q;
  reg [31:0] bus_cnt_q;
  reg txd_q;
  wire txd_to = (txd_cnt_q >= TXD_TO_CYC);
  wire bus_to = (bus_cnt_q >= BUS_TO_CYC);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_q <= 1'b1;
      txd_cnt_q <= 32'h00000000;
      bus_cnt_q <= 32'h00000000;
    end else begin
      txd_q <= txd;
      if (txd) begin
        txd_cnt_q <= 32'h00000000; // [RULE_09]
      end else if (txd_q) begin
        txd_cnt_q <= 32'h00000001; // [RULE_06]
      end else if (!txd_to) begin
        txd_cnt_q <= txd_cnt_q + 32'h00000001; // [RULE_20]
      end
      if (!bus_dominant) begin
        bus_cnt_q <= 32'h00000000;
      end else if (!bus_to) begin
        bus_cnt_q <= bus_cnt_q + 32'h00000001; // [RULE_20]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Local failure causes and flag.

  reg fail_txd_q;
  reg fail_short_q;
  reg fail_bus_q;
  reg fail_ot_q;
  reg ot_hold_q;
  reg txd_seen_high_q;
  reg [1:0] ctrl_q;

  // The RXD pin is read back: low while we drive it recessive and TXD is low means a short.
  wire short_det = rxd && !rxd_pin && !txd;
  wire lf = fail_txd_q || fail_short_q || fail_bus_q || fail_ot_q;
  // A failure counts as resolved only while none of its causes is still present.
  wire resolved = txd && !short_det && !bus_to && !thermal_shutdown_temp;
  wire rxd_dom_txd_rec = !rxd && txd;
  wire clr_all = pwon || (resolved && (enter_normal || rxd_dom_txd_rec)); // [RULE_03] [RULE_04] [RULE_05]
  wire clr_bus = !bus_dominant && !fail_txd_q && !fail_short_q && !fail_ot_q; // [RULE_13]

  wire set_txd = active && txd_to; // [RULE_07]
  wire set_short = active && short_det; // [RULE_10]
  wire set_bus = active && bus_to; // [RULE_11]
  wire set_ot = active && thermal_shutdown_temp;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_txd_q <= 1'b0;
      fail_short_q <= 1'b0;
      fail_bus_q <= 1'b0;
      fail_ot_q <= 1'b0;
    end else begin
      // A failure that is still present wins over a clear in the same cycle.
      fail_txd_q <= (fail_txd_q && !clr_all) || set_txd; // [RULE_01]
      fail_short_q <= (fail_short_q && !clr_all) || set_short; // [RULE_01]
      fail_bus_q <= (fail_bus_q && !clr_all && !clr_bus) || set_bus; // [RULE_01]
      fail_ot_q <= (fail_ot_q && !clr_all) || set_ot; // [RULE_01]
    end
  end

  // The overtemperature hold outlives the failure bit: the drivers stay off until the
  // release indication is seen and the flag has been cleared.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_hold_q <= 1'b0;
    end else if (thermal_shutdown_temp) begin
      ot_hold_q <= 1'b1;
    end else if (thermal_release_temp && !fail_ot_q) begin
      ot_hold_q <= 1'b0; // [RULE_14]
    end
  end

  // TXD must be seen high once in Normal mode before the first transmission.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_seen_high_q <= 1'b0;
    end else if (!in_normal) begin
      txd_seen_high_q <= 1'b0;
    end else if (txd) begin
      txd_seen_high_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin outputs.

  // A bus-dominant failure is left out on purpose: the transmitter stays usable.
  wire tx_block = fail_txd_q || fail_short_q || set_txd || set_short; // [RULE_08] [RULE_12]
  wire drv_off = ot_hold_q || thermal_shutdown_temp; // [RULE_14]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_enable <= 1'b0;
      rxd <= 1'b1;
      err_n <= 1'b1;
    end else begin
      tx_enable <= in_normal && txd_seen_high_q && !tx_block && !drv_off
        && ctrl_q[`CLF_CTRL_TX_ALLOW]; // [RULE_07] [RULE_10]
      rxd <= !bus_dominant;
      if (in_listen && lo_from_norm_q) begin
        err_n <= !lf; // [RULE_02] [RULE_19]
      end else begin
        err_n <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wake pin.

  // The wake level passes the same settling filter as the mode inputs.
  reg wake_ev_q;
  reg wake_lvl_init_q;

  clf_stable_filter #(
    .CNT_W(32),
    .TERM(WAKE_CYC),
    .RST_VAL(1'b0)
  ) u_wake_fltr (
    .clk(pclk),
    .rst_n(presetn),
    .d(wake_pin),
    .q_q(wake_f),
    .changed_q(wake_chg)
  ); // [RULE_16] [RULE_17] [RULE_20]

  // A settled change of the wake level is reported only while wake reports are enabled.
  wire wake_hit = wake_chg && ctrl_q[`CLF_CTRL_WAKE_EN];
  // Writing one to the event bit clears it, but a wake in the same cycle wins.
  wire ev_wr = psel && penable && pready && pwrite && (paddr == `CLF_OFS_EVENT);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pullup <= 1'b0;
      local_wake <= 1'b0;
      wake_ev_q <= 1'b0;
      wake_lvl_init_q <= 1'b0;
    end else begin
      wake_lvl_init_q <= 1'b1;
      wake_pullup <= wake_f; // [RULE_18]
      local_wake <= wake_hit && wake_lvl_init_q; // [RULE_16]
      wake_ev_q <= (wake_ev_q && !(ev_wr && pwdata[`CLF_EV_WAKE])) || (wake_hit && wake_lvl_init_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state per transfer.

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `CLF_OFS_CTRL) || (a == `CLF_OFS_STATUS) || (a == `CLF_OFS_EVENT);
    end
  endfunction

  // Read data is captured in the first access cycle so that it stands with pready.
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h00000000;
    case (paddr)
      `CLF_OFS_CTRL: rd_d[1:0] = ctrl_q;
      `CLF_OFS_STATUS: begin
        rd_d[`CLF_ST_LF] = lf;
        rd_d[`CLF_ST_TXD] = fail_txd_q;
        rd_d[`CLF_ST_SHORT] = fail_short_q;
        rd_d[`CLF_ST_BUS] = fail_bus_q;
        rd_d[`CLF_ST_OT] = fail_ot_q;
        rd_d[`CLF_ST_TXEN] = tx_enable;
        rd_d[`CLF_ST_NORMAL] = in_normal;
        rd_d[`CLF_ST_LISTEN] = in_listen;
        rd_d[`CLF_ST_WAKELVL] = wake_f;
      end
      `CLF_OFS_EVENT: rd_d[`CLF_EV_WAKE] = wake_ev_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_q <= `CLF_CTRL_RST;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped(paddr);
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_d;
      end
      if (psel && penable && pready && pwrite && (paddr == `CLF_OFS_CTRL)) begin
        ctrl_q <= pwdata[1:0];
      end
    end
  end

endmodule // clf_local_failure
`default_nettype wire

/* tb/clf_host.sv */
// Host controller model: drives transmit data and can short it to receive.
// Assumes commands change just after a pclk edge.
`timescale 1ns/1ps
`default_nettype none
module clf_host (
  // Commands.
  input wire logic tx_lvl,
  input wire logic short_en,
  // Pins.
  input wire logic rxd,
  output logic txd,
  output logic rxd_pin
);
  assign txd = tx_lvl;
  // A short makes the read-back pin follow the transmit line.
  assign rxd_pin = short_en ? txd : rxd;
endmodule // clf_host
`default_nettype wire

/* tb/clf_asserts.sv */
// Port checks of the local failure and wake block.
// Assumes the short bench timings; bound into the design below.
`timescale 1ns/1ps
`default_nettype none
module clf_chk #(
  parameter TXD_TO_CYC = 20,
  parameter WAKE_CYC = 8
) (
  // Clock, reset and APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins.
  input wire logic txd,
  input wire logic bus_dominant,
  input wire logic rxd,
  input wire logic err_n,
  input wire logic tx_enable,
  input wire logic standby_select_n,
  input wire logic wake_pin,
  input wire logic wake_pullup,
  input wire logic local_wake
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int low_q;
  int same_q;
  logic last_q;
  // Counts consecutive low transmit samples and stable wake samples.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 0;
      same_q <= 0;
      last_q <= 1'b0;
    end else begin
      low_q <= txd ? 0 : low_q + 1;
      same_q <= (wake_pin == last_q) ? same_q + 1 : 0;
      last_q <= wake_pin;
    end
  end
  sequence apb_take_s;
    psel && penable && !pready;
  endsequence
  sequence stby_s;
    !standby_select_n [*8];
  endsequence
  apb_wait_a: assert property (apb_take_s |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("lone slverr");
  unmapped_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped data");
  rxd_follow_a: assert property (rxd == !$past(bus_dominant)) else $error("rxd lag");
  txd_timeout_a: assert property (low_q > TXD_TO_CYC + 4 |-> !tx_enable)
    else $error("tx still on");
  standby_quiet_a: assert property (stby_s |-> err_n && !tx_enable)
    else $error("standby outputs");
  wake_stable_a: assert property (local_wake |-> same_q >= WAKE_CYC - 2 ##1 !local_wake)
    else $error("early wake");
  bias_follow_a: assert property ($changed(wake_pullup) |->
    wake_pullup == wake_pin && same_q >= WAKE_CYC - 2) else $error("bias early");
endmodule // clf_chk
bind clf_local_failure clf_chk #(.TXD_TO_CYC(TXD_TO_CYC), .WAKE_CYC(WAKE_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd), .bus_dominant(bus_dominant),
  .rxd(rxd), .err_n(err_n), .tx_enable(tx_enable), .standby_select_n(standby_select_n),
  .wake_pin(wake_pin), .wake_pullup(wake_pullup), .local_wake(local_wake));
`default_nettype wire

/* tb/tb_can_local_failure_and_wake_logic.sv */
// Self-checking bench of the local failure and wake block.
// Assumes the design, host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "clf_regs.vh"
module tb_can_local_failure_and_wake_logic;
  localparam int TO = 20;
  localparam int WK = 8;
  localparam logic [8:0] LF = 9'h001 << `CLF_ST_LF;
  localparam logic [8:0] TF = 9'h001 << `CLF_ST_TXD;
  localparam logic [8:0] SH = 9'h001 << `CLF_ST_SHORT;
  localparam logic [8:0] BU = 9'h001 << `CLF_ST_BUS;
  localparam logic [8:0] OT = 9'h001 << `CLF_ST_OT;
  localparam logic [8:0] TE = 9'h001 << `CLF_ST_TXEN;
  localparam logic [8:0] NM = 9'h001 << `CLF_ST_NORMAL;
  logic pclk = 1'b0;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_lvl = 1'b1;
  logic short_en = 1'b0, standby_select_n = 1'b0, enable = 1'b0, bus = 1'b0, pwon = 1'b0;
  logic tsd = 1'b0, trel = 1'b1, wake = 1'b0, perr;
  logic [7:0] paddr = 8'h00, seed = 8'h32;
  logic [31:0] pwdata = 32'h0, rdat, ctrl_m;
  wire [31:0] prdata;
  wire pready, pslverr, txd, rxd_pin, rxd, err_n, tx_enable, wake_pullup, local_wake;
  int mismatches = 0;
  int total_checks = 0;
  int wakes = 0;
  clf_local_failure #(.TXD_TO_CYC(TO), .BUS_TO_CYC(TO), .FLTR_CYC(4), .WAKE_CYC(WK)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txd(txd), .rxd_pin(rxd_pin), .rxd(rxd), .err_n(err_n),
    .standby_select_n(standby_select_n), .enable(enable), .bus_dominant(bus),
    .tx_enable(tx_enable), .pwon(pwon), .thermal_shutdown_temp(tsd),
    .thermal_release_temp(trel), .wake_pin(wake), .wake_pullup(wake_pullup),
    .local_wake(local_wake));
  clf_host i_host (.tx_lvl(tx_lvl), .short_en(short_en), .rxd(rxd), .txd(txd),
    .rxd_pin(rxd_pin));
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (local_wake === 1'b1) wakes <= wakes + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      mismatches++;
      summarize();
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rs(input logic [8:0] e);
    apb(1'b0, `CLF_OFS_STATUS, 32'h0);
    chk(rdat & 32'h1FF, {23'h0, e});
  endtask
  task automatic fin(input int i);
    $display("test %0d done", i);
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Rule model of the wake pin: a new level that stands WK samples is one local wake,
  // and the bias then follows that level.
  int stand_m = 0;
  logic lvl_m = 1'b0;
  logic lvl_q[$];
  always @(posedge pclk) begin
    if (presetn !== 1'b1 || wake === lvl_m) begin
      stand_m <= 0;
    end else if (stand_m == WK - 1) begin
      stand_m <= 0;
      lvl_m <= wake;
      lvl_q.push_back(wake);
    end else begin
      stand_m <= stand_m + 1;
    end
    if (local_wake === 1'b1) begin
      if (lvl_q.size() == 0) chk(local_wake, 0);
      else chk(wake_pullup, lvl_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    presetn <= 1'b1;
    apb(1'b0, `CLF_OFS_CTRL, 32'h0);
    chk(rdat, 32'h3);
    repeat (4) begin
      seed = lfsr(seed);
      ctrl_m = {24'h0, seed} & 32'h3;
      apb(1'b1, `CLF_OFS_CTRL, {24'h0, seed});
      apb(1'b0, `CLF_OFS_CTRL, 32'h0);
      chk(rdat, ctrl_m);
    end
    apb(1'b1, `CLF_OFS_CTRL, 32'h3);
    apb(1'b0, 8'h0C, 32'h0);
    chk({rdat[30:0], perr}, 32'h1);
    bus <= 1'b1;
    cyc(TO + 10);
    bus <= 1'b0;
    cyc(3);
    rs(9'h000);
    fin(1);
    standby_select_n <= 1'b1;
    enable <= 1'b1;
    cyc(10);
    enable <= 1'b0;
    cyc(3);
    chk(tx_enable, 1);
    enable <= 1'b1;
    cyc(10);
    rs(NM | TE);
    tx_lvl <= 1'b0;
    cyc(TO - 5);
    tx_lvl <= 1'b1;
    cyc(1);
    tx_lvl <= 1'b0;
    cyc(TO - 5);
    tx_lvl <= 1'b1;
    cyc(2);
    rs(NM | TE);
    tx_lvl <= 1'b0;
    cyc(TO + 5);
    tx_lvl <= 1'b1;
    cyc(3);
    rs(NM | LF | TF);
    chk(err_n, 1);
    enable <= 1'b0;
    cyc(10);
    chk(err_n, 0);
    standby_select_n <= 1'b0;
    cyc(10);
    chk(err_n, 1);
    standby_select_n <= 1'b1;
    cyc(10);
    chk(err_n, 1);
    enable <= 1'b1;
    cyc(10);
    rs(NM | TE);
    fin(2);
    short_en <= 1'b1;
    tx_lvl <= 1'b0;
    cyc(3);
    tx_lvl <= 1'b1;
    short_en <= 1'b0;
    cyc(3);
    rs(NM | LF | SH);
    bus <= 1'b1;
    cyc(3);
    bus <= 1'b0;
    cyc(3);
    rs(NM | TE);
    fin(3);
    bus <= 1'b1;
    cyc(TO + 5);
    rs(NM | TE | LF | BU);
    bus <= 1'b0;
    cyc(3);
    rs(NM | TE);
    fin(4);
    trel <= 1'b0;
    tsd <= 1'b1;
    cyc(3);
    tsd <= 1'b0;
    cyc(3);
    rs(NM | LF | OT);
    pwon <= 1'b1;
    cyc(1);
    pwon <= 1'b0;
    cyc(3);
    rs(NM);
    trel <= 1'b1;
    cyc(3);
    rs(NM | TE);
    fin(5);
    apb(1'b1, `CLF_OFS_EVENT, 32'h1);
    wake <= 1'b1;
    cyc(WK + 6);
    apb(1'b0, `CLF_OFS_EVENT, 32'h0);
    chk(rdat, 32'h1);
    chk(wake_pullup, 1);
    apb(1'b1, `CLF_OFS_EVENT, 32'h1);
    wake <= 1'b0;
    cyc(3);
    wake <= 1'b1;
    cyc(WK + 6);
    apb(1'b0, `CLF_OFS_EVENT, 32'h0);
    chk(rdat, 32'h0);
    chk(wakes, 1);
    fin(6);
    chk(lvl_q.size(), 0);
    summarize();
  end
endmodule // tb_can_local_failure_and_wake_logic
`default_nettype wire
